// >>> fwr_receiver.sv
// FSK word receiver: framing, three-wire word interface, carrier and tone qualify.
// Assumes asynchronous pin inputs, one 20 MHz clock, AXI4-Lite register access.
`timescale 1ns/10ps
`include "fwr_consts.svh"
module fwr_receiver
  import fwr_pkg::*;
#(
  parameter int BIT_CYC  = `FWR_CLK_HZ / `FWR_BAUD,
  parameter int HALF_CYC = (`FWR_CLK_HZ + `FWR_HALF_DIV - 1) / `FWR_HALF_DIV,
  parameter int HOLD_CYC = `FWR_CLK_HZ / 1000 * `FWR_CS_HOLD_MS,
  parameter int QUAL_CYC = `FWR_CLK_HZ / 1000 * `FWR_CS_QUAL_MS,
  parameter int GON_CYC  = `FWR_CLK_HZ / 1000 * `FWR_GUARD_ON_MS,
  parameter int GOFF_CYC = `FWR_CLK_HZ / 1000 * `FWR_GUARD_OFF_MS
)(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        demod_bit,
  input  wire logic        band_energy,
  input  wire logic        mode_sel,
  input  wire logic        power_down_pin,
  input  wire logic        demod_enable,
  input  wire logic        raw_tone_in,
  input  wire logic        call_trigger_input,
  input  wire logic        shift_clock_i,
  output logic             shift_clock_o,
  output logic             shift_clock_oe,
  output logic             data_out,
  output logic             word_ready_n,
  output logic             carrier_sense_n,
  output logic             raw_tone_flag,
  output logic             qualified_tone_detect,
  output logic             call_arrival_n,
  output logic             irq_n_o,
  output logic             irq_n_oe
);
  localparam int TW = $clog2(BIT_CYC + 1);                 // Bit timer width
  localparam int CW = $clog2(HOLD_CYC + QUAL_CYC + 1);     // Carrier timer width
  localparam int GW = $clog2(GON_CYC + GOFF_CYC + 1);      // Guard timer width

  fwr_pins_t     s1_q;        // First synchroniser stage, read by pin_q only
  fwr_pins_t     pin_q;       // Second stage, safe to use
  logic          sck_d1_q;    // Delayed host clock for edge detect
  fwr_state_t    st_q;        // Framing state
  logic [TW-1:0] tmr_q;       // Bit cell timer
  logic [3:0]    nbit_q;      // Data bits taken so far
  logic [7:0]    rx_sr_q;     // Assembly register, LSB arrives first
  logic [7:0]    out_sr_q;    // Mode 1 output shift register
  logic [3:0]    out_cnt_q;   // Mode 1 bits shifted out
  logic          sclk_q;      // Mode 0 shift clock
  logic          wr_n_q;      // Word ready, active low
  logic [TW-1:0] wr_tmr_q;    // Word ready low-time counter
  logic          data_q;      // Data pin register
  logic          cs_n_q;      // Carrier sense, active low
  logic [CW-1:0] cs_tmr_q;    // Carrier qualify/hold counter
  logic          raw_q;       // Registered raw tone
  logic          qtd_q;       // Guard-qualified tone
  logic [GW-1:0] gd_tmr_q;    // Guard timer
  logic          call_n_q;    // Call arrival output
  logic          irq_q;       // Interrupt asserted
  logic          ctrl_en_q;   // Software receive enable
  logic [7:0]    word_q;      // Last completed word
  logic [7:0]    wcnt_q;      // Completed word count
  logic [31:0]   rdata_q;     // Read data register

  // Power-down holds the whole core in reset except synchronisers, call path, interrupt and bus
  wire core_rst   = !aresetn || pin_q.pd;                                   // R22
  wire mode1      = pin_q.mode;                                             // R1
  wire rx_on      = !cs_n_q && pin_q.den && ctrl_en_q;                      // R15 R16
  wire tick       = (tmr_q == '0);
  wire host_rise  = mode1 && pin_q.sck && !sck_d1_q;
  wire last_bit   = (st_q == FWR_DATA) && tick && (nbit_q == `FWR_NBITS - 4'h1);
  wire load1      = mode1 && last_bit;                                      // R8
  wire set0       = !mode1 && (st_q == FWR_STOP) && tick;                   // R6
  wire [7:0] next_sr = {pin_q.demod, rx_sr_q[7:1]};
  wire wr_release = (wr_tmr_q == '0) || (mode1 && host_rise) || (!mode1 && !rx_on);
  wire cs_zero    = (cs_tmr_q == '0);
  wire g_hit      = qtd_q ? (gd_tmr_q >= GW'(GOFF_CYC - 1)) : (gd_tmr_q >= GW'(GON_CYC - 1));

  // Two-flop synchronisers for every pin input
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1_q     <= '0;
      pin_q    <= '0;
      sck_d1_q <= 1'b0;
    end
    else
    begin
      s1_q     <= {shift_clock_i, call_trigger_input, raw_tone_in, demod_enable,
                   power_down_pin, mode_sel, band_energy, demod_bit};
      pin_q    <= s1_q;
      sck_d1_q <= pin_q.sck;
    end
  end

  // Call path keeps running during power-down; trigger high means call present
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      call_n_q <= 1'b1;
    else
      call_n_q <= !pin_q.trig;                                              // R22
  end

  // Framing machine; bit timing is a divide of the fabric clock
  always_ff @(posedge aclk)
  begin
    if (core_rst || !rx_on)
    begin
      st_q   <= FWR_IDLE;                                                   // R15
      tmr_q  <= '0;
      nbit_q <= '0;
    end
    else
    begin
      tmr_q <= tick ? '0 : tmr_q - TW'(1);                                  // R24
      case (st_q)
        FWR_IDLE:
          if (!pin_q.demod)
          begin
            st_q  <= FWR_START;
            tmr_q <= TW'(BIT_CYC / 2 - 1);                                  // R2
          end
        FWR_START:
          if (tick)
          begin
            // A start bit that is gone by mid cell was a glitch
            st_q   <= pin_q.demod ? FWR_IDLE : FWR_DATA;
            tmr_q  <= TW'(BIT_CYC - 1);
            nbit_q <= '0;
          end
        FWR_DATA:
          if (tick)
          begin
            nbit_q <= nbit_q + 4'h1;
            tmr_q  <= TW'(BIT_CYC - 1);
            if (last_bit)
              st_q <= FWR_STOP;
          end
        default:
          if (tick)
            st_q <= FWR_IDLE;   // Stop bit centre; hunt for next start
      endcase
    end
  end

  // Assembly register, shifted at each data-cell centre
  always_ff @(posedge aclk)
  begin
    if (core_rst)
      rx_sr_q <= '0;
    else if (rx_on && st_q == FWR_DATA && tick)
      rx_sr_q <= next_sr;                                                   // R2
  end

  // Mode 0 shift clock: rises at cell centre, falls half a cell later
  always_ff @(posedge aclk)
  begin
    if (core_rst || mode1 || !rx_on)
      sclk_q <= 1'b0;                                                       // R15
    else if (st_q == FWR_DATA && tick)
      sclk_q <= 1'b1;                                                       // R4 R5
    else if (tmr_q == TW'(BIT_CYC / 2))
      sclk_q <= 1'b0;
  end

  // Word ready: set wins over release so a new word is never lost
  always_ff @(posedge aclk)
  begin
    if (core_rst)
    begin
      wr_n_q   <= 1'b1;
      wr_tmr_q <= '0;
    end
    else if (load1 || set0)
    begin
      wr_n_q   <= 1'b0;                                                     // R6 R8
      wr_tmr_q <= TW'(HALF_CYC - 1);
    end
    else if (!wr_n_q)
    begin
      wr_tmr_q <= wr_tmr_q - TW'(1);
      if (wr_release)
        wr_n_q <= 1'b1;                                                     // R10 R11
    end
  end

  // Mode 1 output register: parallel load, then host-clocked shifting
  always_ff @(posedge aclk)
  begin
    if (core_rst)
    begin
      out_sr_q  <= '0;
      out_cnt_q <= `FWR_NBITS;
    end
    else if (load1)
    begin
      out_sr_q  <= next_sr;                                                 // R8
      out_cnt_q <= '0;
    end
    else if (host_rise && out_cnt_q != `FWR_NBITS)
    begin
      out_sr_q  <= {1'b1, out_sr_q[7:1]};                                   // R9
      out_cnt_q <= out_cnt_q + 4'h1;                                        // R12
    end
  end

  // Data pin: mode 1 shows out_sr_q[0]; mode 0 raw bits, forced high without carrier
  always_ff @(posedge aclk)
  begin
    if (core_rst)
      data_q <= 1'b1;
    else if (mode1)
      data_q <= out_sr_q[0];                                                // R9
    else
      data_q <= rx_on ? pin_q.demod : 1'b1;                                 // R3 R15
  end

  // Carrier sense: qualify then hold through dropouts
  always_ff @(posedge aclk)
  begin
    if (core_rst)
    begin
      cs_n_q   <= 1'b1;
      cs_tmr_q <= '0;
    end
    else if (cs_n_q)
    begin
      // Energy must stay present for the whole qualify time
      cs_tmr_q <= pin_q.energy ? cs_tmr_q + CW'(1) : '0;                    // R13
      if (pin_q.energy && cs_tmr_q >= CW'(QUAL_CYC - 1))
      begin
        cs_n_q   <= 1'b0;
        cs_tmr_q <= CW'(HOLD_CYC - 1);
      end
    end
    else if (pin_q.energy)
      cs_tmr_q <= CW'(HOLD_CYC - 1);                                        // R14
    else if (cs_zero)
      cs_n_q <= 1'b1;                                                       // R14
    else
      cs_tmr_q <= cs_tmr_q - CW'(1);
  end

  // Tone path: guard timer needs a steady opposite level to flip
  always_ff @(posedge aclk)
  begin
    if (core_rst)
    begin
      raw_q    <= 1'b0;                                                     // R21
      qtd_q    <= 1'b0;                                                     // R21
      gd_tmr_q <= '0;
    end
    else
    begin
      raw_q <= pin_q.tone;
      if (raw_q == qtd_q)
        gd_tmr_q <= '0;
      else if (g_hit)
      begin
        qtd_q    <= raw_q;                                                  // R23
        gd_tmr_q <= '0;
      end
      else
        gd_tmr_q <= gd_tmr_q + GW'(1);
    end
  end

  // Interrupt level from the three sources; open drain pulls low
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_q <= 1'b0;
    else
      irq_q <= !call_n_q || qtd_q || !wr_n_q;                               // R18
  end

  // Word log for software
  always_ff @(posedge aclk)
  begin
    if (core_rst)
    begin
      word_q <= '0;
      wcnt_q <= '0;
    end
    else if (last_bit)
    begin
      word_q <= next_sr;
      wcnt_q <= wcnt_q + 8'h01;
    end
  end

  // AXI4-Lite write: address and data taken together, one at a time
  wire wr_go    = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  wire wr_ctrl  = (s_axi_awaddr == `FWR_OFF_CTRL);
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_en_q    <= `FWR_CTRL_RST;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `FWR_RESP_OK;
    end
    else if (wr_go)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ctrl ? `FWR_RESP_OK : `FWR_RESP_ERR;
      if (wr_ctrl && s_axi_wstrb[0])
        ctrl_en_q <= s_axi_wdata[0];
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // AXI4-Lite read: decode chain, unmapped words read zero with error
  wire rd_go  = s_axi_arvalid && !s_axi_rvalid;
  wire rd_c   = (s_axi_araddr == `FWR_OFF_CTRL);
  wire rd_s   = (s_axi_araddr == `FWR_OFF_STAT);
  wire rd_w   = (s_axi_araddr == `FWR_OFF_WORD);
  wire [31:0] stat_w = {24'h00_0000, mode1, pin_q.pd, cs_n_q, wr_n_q,
                        qtd_q, call_n_q, raw_q, irq_q};
  wire [31:0] rd_mux = rd_c ? {31'h0000_0000, ctrl_en_q} :
                       rd_s ? stat_w :
                       rd_w ? {16'h0000, wcnt_q, word_q} : 32'h0000_0000;
  assign s_axi_arready = rd_go;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= `FWR_RESP_OK;
      rdata_q      <= '0;
    end
    else if (rd_go)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= (rd_c || rd_s || rd_w) ? `FWR_RESP_OK : `FWR_RESP_ERR;
      rdata_q      <= rd_mux;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // Pin drive; shift clock pin is ours only in mode 0
  assign s_axi_rdata           = rdata_q;
  assign shift_clock_o         = sclk_q;
  assign shift_clock_oe        = !mode1;                                    // R1
  assign data_out              = data_q;
  assign word_ready_n          = wr_n_q;
  assign carrier_sense_n       = cs_n_q;
  assign raw_tone_flag         = raw_q;
  assign qualified_tone_detect = qtd_q;
  assign call_arrival_n        = call_n_q;
  assign irq_n_o               = 1'b0;
  assign irq_n_oe              = irq_q;

  // Checks
  property p_sclk_centre;
    @(posedge aclk) disable iff (core_rst)
    $rose(sclk_q) |-> $past(st_q == FWR_DATA && tick);
  endproperty
  a_sclk_centre: assert property (p_sclk_centre) else $error("clock edge off centre"); // R5
  // A settled mode 1 must neither enable nor toggle our clock driver
  property p_mode1_nodrive;
    @(posedge aclk) disable iff (!aresetn)
    pin_q.mode ##1 pin_q.mode |-> !shift_clock_oe && !sclk_q;
  endproperty
  a_mode1_nodrive: assert property (p_mode1_nodrive) else $error("drove clock in mode 1"); // R1
  property p_ready_width0;
    @(posedge aclk) disable iff (core_rst)
    ($fell(wr_n_q) && !mode1 && rx_on) |-> (!wr_n_q && rx_on && !mode1)[*8];
  endproperty
  a_ready_width0: assert property (p_ready_width0) else $error("ready pulse short"); // R6
  property p_host_release;
    @(posedge aclk) disable iff (core_rst)
    (mode1 && !wr_n_q && host_rise && !load1) |=> wr_n_q;
  endproperty
  a_host_release: assert property (p_host_release) else $error("ready not released"); // R10
  property p_ignore_extra;
    @(posedge aclk) disable iff (core_rst)
    (out_cnt_q == `FWR_NBITS && host_rise && !load1) |=> $stable(out_sr_q) && $stable(out_cnt_q);
  endproperty
  a_ignore_extra: assert property (p_ignore_extra) else $error("extra clock shifted"); // R12
  property p_load_fresh;
    @(posedge aclk) disable iff (core_rst)
    ($fell(wr_n_q) && mode1) |-> out_cnt_q == 4'h0 && out_sr_q == word_q;
  endproperty
  a_load_fresh: assert property (p_load_fresh) else $error("ready without load"); // R8
  property p_idle_high;
    @(posedge aclk) disable iff (core_rst)
    (!mode1 && cs_n_q) ##1 (!mode1 && cs_n_q) |-> data_q && !sclk_q;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("data active without carrier"); // R15
  property p_cs_release;
    @(posedge aclk) disable iff (core_rst)
    $rose(cs_n_q) |-> $past(cs_zero && !pin_q.energy);
  endproperty
  a_cs_release: assert property (p_cs_release) else $error("carrier dropped early"); // R14
  property p_pd_low;
    @(posedge aclk) disable iff (!aresetn)
    pin_q.pd |=> !qtd_q && !raw_q;
  endproperty
  a_pd_low: assert property (p_pd_low) else $error("tone high in power-down"); // R21
  property p_irq;
    @(posedge aclk) disable iff (!aresetn)
    (!call_n_q || qtd_q || !wr_n_q) |=> irq_n_oe && !irq_n_o;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing"); // R18
  c_word0: cover property (@(posedge aclk) disable iff (core_rst) set0);
  c_word1: cover property (@(posedge aclk) disable iff (core_rst) load1);
  c_hostclr: cover property (@(posedge aclk) disable iff (core_rst) !wr_n_q && host_rise);
  c_tone: cover property (@(posedge aclk) disable iff (core_rst) $rose(qtd_q));
endmodule

// >>> fwr_consts.svh
// Constants for the FSK word receiver: offsets, reset values, timing.
// Assumes a single 20 MHz fabric clock and AXI4-Lite register access.
// Function
// R1: Mode pin low selects device-driven mode 0
// R2: Frame 1200 baud words in hardware
// R3: Mode 0 passes demodulated bits to data
// R4: Mode 0 emits eight shift_clock pulses per word
// R5: Shift_clock rises mid data cell only
// R6: Mode 0 pulses word_ready_n once per word
// R7: Mode 1 host supplies shift_clock pulses
// R8: Mode 1 loads word, drops word_ready_n
// R9: Mode 1 shifts out on host edges, arrival order
// R10: First host edge releases word_ready_n
// R11: Without host clock, release after half bit
// R12: Extra host edges after eighth are ignored
// R13: Qualify band energy before carrier_sense_n low
// R14: Hold carrier through dropouts, release after 8ms
// R15: No carrier: ignore demod, data high, no pulses (mode 1 data shows out_sr_q[0])
// R16: No carrier mode 1: no load, no ready
// R17: Host drops demod_enable when FSK not expected
// R18: Irq asserted by call, tone or ready
// R19: Host reads sources to find irq cause
// R20: Host ignores early call and tone irqs
// R21: Power-down forces tone outputs low
// R22: Power-down halts all but call path (code also keeps synchronisers, interrupt and bus running)
// R23: Qualified tone is guard-timed raw detection
// R24: Bit timing divided from master clock
`ifndef FWR_CONSTS_SVH
`define FWR_CONSTS_SVH
`define FWR_CLK_HZ       20000000
`define FWR_BAUD         1200
`define FWR_HALF_DIV     2400
`define FWR_CS_HOLD_MS   8
`define FWR_CS_QUAL_MS   4
`define FWR_GUARD_ON_MS  20
`define FWR_GUARD_OFF_MS 16
`define FWR_NBITS        4'h8
`define FWR_OFF_CTRL     4'h0
`define FWR_OFF_STAT     4'h4
`define FWR_OFF_WORD     4'h8
`define FWR_CTRL_RST     1'b1
`define FWR_RESP_OK      2'b00
`define FWR_RESP_ERR     2'b10
`endif

// >>> fwr_pkg.sv
// Types shared by the FSK word receiver.
// Assumes fwr_consts.svh supplies the numeric constants.
package fwr_pkg;
  // Receive framing states
  typedef enum logic [1:0] {FWR_IDLE, FWR_START, FWR_DATA, FWR_STOP} fwr_state_t;
  // Synchronised pin inputs, travelling together
  typedef struct packed {
    logic sck;     // Host shift clock
    logic trig;    // Call trigger comparator
    logic tone;    // Raw dual-tone detection
    logic den;     // Demodulator enable
    logic pd;      // Power-down pin
    logic mode;    // Mode select
    logic energy;  // In-band energy present
    logic demod;   // Demodulated bit
  } fwr_pins_t;
endpackage

// >>> fwr_host_model.sv
// Host-side partner: collects words from the three-wire word interface.
// Assumes the receiver drives data_out and word_ready_n; host clock runs only to read.
`timescale 1ns/10ps
module fwr_host_model (
  input  wire logic       mode_sel,
  input  wire logic       shift_clock_o,
  input  wire logic       data_out,
  input  wire logic       word_ready_n,
  input  wire logic [3:0] npulse,        // Pulses per word in mode 1, 0 never reads
  output logic            shift_clock_i,
  output logic [7:0]      word_q,        // Last word assembled
  output logic [3:0]      cnt_q          // Mode 0 clock rises in last word
);
  logic [7:0] sh;   // Assembly register, first bit lands in bit 0
  logic [3:0] cnt;  // Mode 0 rises since last ready
  initial
  begin
    shift_clock_i = 1'b0;
    sh = 8'h00;
    cnt = 4'h0;
  end
  // Mode 0: take data on each device clock rise
  always @(posedge shift_clock_o)
  begin
    if (!mode_sel)
    begin
      sh = {data_out, sh[7:1]};
      cnt = cnt + 4'h1;
    end
  end
  // Ready falls: mode 0 latches, mode 1 clocks the word out
  always @(negedge word_ready_n)
  begin
    if (!mode_sel)
    begin
      word_q = sh;
      cnt_q = cnt;
      cnt = 4'h0;
    end
    else if (npulse != 4'h0)
    begin
      // Odd offset keeps host edges unrelated to aclk
      #130;
      for (int i = 0; i < npulse; i++)
      begin
        if (i < 8)
          sh = {data_out, sh[7:1]};
        shift_clock_i = 1'b1;
        #200;
        shift_clock_i = 1'b0;
        #200;
      end
      word_q = sh;
    end
  end
endmodule

// >>> tb.sv
// Self-checking bench for the FSK word receiver.
// Assumes short timing parameters; a host model sits on the word interface.
`timescale 1ns/10ps
module tb;
  import fwr_pkg::*;
  localparam int BIT = 40, HALF = 20, HOLD = 200, QUAL = 50, GON = 30, GOFF = 20;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_wstrb = 4'h0, s_axi_araddr = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        demod_bit = 1'b1, band_energy = 1'b0, mode_sel = 1'b0, power_down_pin = 1'b0;
  logic        demod_enable = 1'b1, raw_tone_in = 1'b0, call_trigger_input = 1'b0;
  logic        shift_clock_i, shift_clock_o, shift_clock_oe, data_out, word_ready_n;
  logic        carrier_sense_n, raw_tone_flag, qualified_tone_detect, call_arrival_n;
  logic        irq_n_o, irq_n_oe;
  logic [3:0]  npulse = 4'h8, cnt_q;
  logic [7:0]  word_q, b;
  logic [31:0] d;
  logic [1:0]  r;
  int          err_count = 0, compares = 0, wr_len = 0, last_len = 0, nwords = 0, n0;
  int          seed = 32'h736b_ca25;

  fwr_receiver #(.BIT_CYC(BIT), .HALF_CYC(HALF), .HOLD_CYC(HOLD), .QUAL_CYC(QUAL),
    .GON_CYC(GON), .GOFF_CYC(GOFF)) i_fwr_receiver (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .demod_bit, .band_energy, .mode_sel, .power_down_pin, .demod_enable,
    .raw_tone_in, .call_trigger_input, .shift_clock_i, .shift_clock_o, .shift_clock_oe,
    .data_out, .word_ready_n, .carrier_sense_n, .raw_tone_flag, .qualified_tone_detect,
    .call_arrival_n, .irq_n_o, .irq_n_oe);

  fwr_host_model i_fwr_host_model (.mode_sel, .shift_clock_o, .data_out, .word_ready_n,
    .npulse, .shift_clock_i, .word_q, .cnt_q);

  // 20 MHz clock
  always #25 aclk = ~aclk;

  // Ready pulse width and count, measured in aclk cycles
  always @(posedge aclk)
  begin
    if (!word_ready_n)
      wr_len <= wr_len + 1;
    else if (wr_len != 0)
    begin
      last_len <= wr_len;
      wr_len <= 0;
      nwords <= nwords + 1;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask

  // Line frame of a word: start 0, data LSB first, stop 1
  function automatic logic [9:0] frame(input logic [7:0] v);
    return {1'b1, v, 1'b0};
  endfunction

  // One start bit, eight data bits first-bit-first, one stop bit
  task automatic send(input logic [7:0] v);
    logic [9:0] f;
    f = frame(v);
    for (int i = 0; i < 10; i++)
    begin
      demod_bit <= f[i];
      cyc(BIT);
    end
    cyc(BIT);
  endtask

  // Write: address and data offered together, each held until taken
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rr);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!(s_axi_awready && s_axi_wready));
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_bvalid);
    rr = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rr);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    v = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic summarize();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Watchdog: the whole run needs well under a millisecond
  initial
  begin
    #2_000_000;
    err_count++;
    summarize();
  end

  initial
  begin
    cyc(6);
    aresetn <= 1'b1;
    cyc(4);
    check(data_out, 1'b1);
    check(word_ready_n, 1'b1);
    check(carrier_sense_n, 1'b1);
    check(irq_n_oe, 1'b0);
    check(shift_clock_oe, 1'b1);
    axi_rd(4'h0, d, r);
    check(d[0], 1'b1);
    axi_rd(4'hc, d, r);
    check(r, 2'b10);
    axi_wr(4'hc, 32'h0000_0001, r);
    check(r, 2'b10);
    axi_wr(4'h0, 32'h0000_0001, r);
    check(r, 2'b00);
    done("reset_and_bus");
    // No carrier: data pinned high, no word
    n0 = nwords;
    demod_bit <= 1'b0;
    cyc(10);
    check(data_out, 1'b1);
    demod_bit <= 1'b1;
    send(8'h5a);
    check(nwords, n0);
    done("no_carrier_mode0");
    // Carrier needs qualification before it shows
    band_energy <= 1'b1;
    cyc(QUAL / 2);
    check(carrier_sense_n, 1'b1);
    cyc(QUAL + 10);
    check(carrier_sense_n, 1'b0);
    done("carrier_on");
    // Mode 0: corner bytes then random ones
    for (int k = 0; k < 6; k++)
    begin
      b = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($random(seed));
      n0 = nwords;
      send(b);
      check(word_q, b);
      check(cnt_q, 4'h8);
      check(last_len, HALF);
      check(nwords, n0 + 1);
    end
    done("mode0_words");
    // Mode 1: host reads promptly, never, and too often
    mode_sel <= 1'b1;
    cyc(4);
    check(shift_clock_oe, 1'b0);
    for (int k = 0; k < 6; k++)
    begin
      b = 8'($random(seed));
      npulse <= (k < 3) ? 4'h8 : (k == 3) ? 4'h0 : 4'ha;
      n0 = nwords;
      send(b);
      check(nwords, n0 + 1);
      if (k == 3)
        check(last_len, HALF);
      else
      begin
        check(word_q, b);
        check(last_len < HALF, 1'b1);
      end
      if (k == 5)
        check(data_out, 1'b1);
    end
    axi_rd(4'h8, d, r);
    check(d[7:0], b);
    done("mode1_words");
    // Receive disabled by the enable pin, then by software: no word framed
    demod_enable <= 1'b0;
    n0 = nwords;
    send(8'h81);
    check(nwords, n0);
    demod_enable <= 1'b1;
    axi_wr(4'h0, 32'h0000_0000, r);
    axi_rd(4'h0, d, r);
    check(d[0], 1'b0);
    send(8'h7e);
    check(nwords, n0);
    axi_wr(4'h0, 32'h0000_0001, r);
    done("receive_gating");
    // Dropout shorter than the hold keeps carrier; longer releases it
    band_energy <= 1'b0;
    cyc(HOLD / 2);
    check(carrier_sense_n, 1'b0);
    cyc(HOLD);
    check(carrier_sense_n, 1'b1);
    n0 = nwords;
    send(8'h3c);
    check(nwords, n0);
    done("carrier_off_mode1");
    // Interrupt sources, guard timing and power-down
    call_trigger_input <= 1'b1;
    cyc(6);
    check(call_arrival_n, 1'b0);
    check(irq_n_oe, 1'b1);
    check(irq_n_o, 1'b0);
    call_trigger_input <= 1'b0;
    cyc(6);
    check(irq_n_oe, 1'b0);
    raw_tone_in <= 1'b1;
    cyc(6);
    check(raw_tone_flag, 1'b1);
    check(qualified_tone_detect, 1'b0);
    cyc(GON + 6);
    check(qualified_tone_detect, 1'b1);
    check(irq_n_oe, 1'b1);
    axi_rd(4'h4, d, r);
    check(d[3], 1'b1);
    power_down_pin <= 1'b1;
    call_trigger_input <= 1'b1;
    cyc(6);
    check(qualified_tone_detect, 1'b0);
    check(raw_tone_flag, 1'b0);
    check(call_arrival_n, 1'b0);
    power_down_pin <= 1'b0;
    call_trigger_input <= 1'b0;
    raw_tone_in <= 1'b0;
    demod_enable <= 1'b0;
    cyc(GOFF + 10);
    check(qualified_tone_detect, 1'b0);
    done("irq_tone_powerdown");
    summarize();
  end
endmodule
